//--- hdl/usf_pkg.sv
/*
 * usf_pkg: constants, types and helpers for the serial frame core.
 * Assumes a 32-bit APB slave with byte addresses on word boundaries.
 */
package usf_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_RX_LO = 8'h00;
  localparam logic [7:0] ADDR_RX_HI = 8'h04;
  localparam logic [7:0] ADDR_TX_LO = 8'h08;
  localparam logic [7:0] ADDR_TX_HI = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CTRLB = 8'h14;
  localparam logic [7:0] ADDR_CTRLC = 8'h18;
  localparam logic [7:0] ADDR_BAUD = 8'h1c;
  // field positions
  localparam int RXH_D8_BIT = 0;
  localparam int RXH_PAR_ERR_BIT = 1;
  localparam int RXH_FRM_ERR_BIT = 2;
  localparam int RXH_OVF_BIT = 6;
  localparam int RXH_RXC_BIT = 7;
  localparam int ST_DRE_BIT = 5;
  localparam int ST_TXC_BIT = 6;
  localparam int ST_RXC_BIT = 7;
  localparam int CB_RXEN_BIT = 0;
  localparam int CB_TXEN_BIT = 1;
  localparam int CC_SIZE_LSB = 0;   // [2:0] char_size_field
  localparam int CC_PAR_LSB = 4;    // [5:4] parity mode
  localparam int CC_STOP2_BIT = 6;
  localparam int CC_SYNC_BIT = 7;
  localparam int CC_DBL_BIT = 8;
  localparam int CC_HOST_BIT = 9;
  // reset values
  localparam logic [1:0] CTRLB_RST = 2'h0;
  localparam logic [9:0] CTRLC_RST = 10'h003;
  localparam logic [15:0] BAUD_RST = 16'h0040;
  // encodings
  localparam logic [2:0] CS_9L = 3'h6;
  localparam logic [2:0] CS_9H = 3'h7;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  // timing counts in baud ticks, and the accumulator step per clk_sys
  localparam logic [3:0] SPB16_LAST = 4'hf;
  localparam logic [3:0] SPB8_LAST = 4'h7;
  localparam logic [3:0] HALF16_LAST = 4'h7;
  localparam logic [3:0] HALF8_LAST = 4'h3;
  localparam logic [16:0] ACC_STEP = 17'h00040;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
  } usf_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } usf_rx_st_t;

  function automatic logic [3:0] char_bits(input logic [2:0] cs);
    case (cs)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      CS_9L, CS_9H: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction : char_bits

  // parity bit for the low n bits of d; odd flips the even result
  function automatic logic par_of(input logic [8:0] d,
                                 input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) p = p ^ d[i];
    end
    par_of = p;
  endfunction : par_of

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a <= ADDR_BAUD);
  endfunction : addr_ok
endpackage : usf_pkg

//--- hdl/usf_baud_gen.sv
/*
 * usf_baud_gen: fractional divider, one-cycle tick per sample period.
 * Assumes the divisor is at least 64 (integer part non-zero).
 */
`timescale 1ns/1ps
module usf_baud_gen (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [15:0] divisor,
  output logic tick
);
  logic [15:0] acc_reg;
  logic [16:0] acc_next;

  // adding 64 per clock against the divisor gives 64*f/divisor ticks
  assign acc_next = {1'b0, acc_reg} + usf_pkg::ACC_STEP;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !enable) begin
      acc_reg <= 16'h0000;
      tick <= 1'b0;
    end else if (acc_next >= {1'b0, divisor}) begin
      acc_reg <= 16'(acc_next - {1'b0, divisor});
      tick <= 1'b1;
    end else begin
      acc_reg <= acc_next[15:0];
      tick <= 1'b0;
    end
  end
endmodule : usf_baud_gen

//--- hdl/usf_core.sv
/*
 * usf_core: serial frame transmitter/receiver with fractional baud
 * generator, APB register slave and two-frame receive buffer.
 * Assumes an APB master on clk_sys and pins outside the clock domain.
 */
// Chosen here: the APB register port and the register addresses.
// What this block does
// - each frame starts with one low start bit, data follows at once
// - parity bit goes after last data bit, before first stop bit
// - 5 to 9 data bits, none/even/odd parity, 1 or 2 stops
// - after stop bits, next start bit or line idles high
// - bit clock from fractional generator, or transfer clock pin
// - async divisor is baud setting over 64, six fraction bits
// - sync mode uses only upper ten integer bits of the setting
// - samples per bit are 16 normal, 8 double speed, 2 sync
// - data register to buffer to shifter, each when next is empty
// - tx complete set when frame ends and nothing is pending
// - unused upper data bits are ignored for short characters
// - transmitter disable waits until all pending data is sent
// - disabled transmitter releases the pin to input
// - receiver starts on a valid start bit, samples to first stop
// - a second stop bit is ignored by the receiver
// - first stop bit moves the frame to buffer, sets rx complete
// - two-frame receive buffer, oldest frame shown
// - 9L mode high-byte read advances, else low-byte read does
// - frame error on bad stop, overflow when full buffer loses data
// - received parity checked, mismatch flagged
// - error flags stored and read with their frame
`timescale 1ns/1ps
module usf_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_pin,
  output logic txd_out,
  output logic txd_oe,
  input wire logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe
);
  ////////////////////////////////////////////////////////////////////////
  // registers and decode
  logic [1:0] ctrlb_reg;
  logic [9:0] ctrlc_reg;
  logic [15:0] baud_reg;
  logic wr_acc, rd_acc, rd_setup;
  logic rxen, txen, stop2, sync_m, dbl, host, is9l, is9h;
  logic [1:0] par_mode;
  logic par_en;
  logic [3:0] nbits;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !usf_pkg::addr_ok(paddr);
  assign rxen = ctrlb_reg[usf_pkg::CB_RXEN_BIT];
  assign txen = ctrlb_reg[usf_pkg::CB_TXEN_BIT];
  assign par_mode = ctrlc_reg[usf_pkg::CC_PAR_LSB +: 2];
  assign par_en = par_mode[1];
  assign stop2 = ctrlc_reg[usf_pkg::CC_STOP2_BIT];
  assign sync_m = ctrlc_reg[usf_pkg::CC_SYNC_BIT];
  assign dbl = ctrlc_reg[usf_pkg::CC_DBL_BIT];
  assign host = ctrlc_reg[usf_pkg::CC_HOST_BIT];
  assign nbits = usf_pkg::char_bits(ctrlc_reg[usf_pkg::CC_SIZE_LSB +: 3]);
  assign is9l = ctrlc_reg[2:0] == usf_pkg::CS_9L;
  assign is9h = ctrlc_reg[2:0] == usf_pkg::CS_9H;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrlb_reg <= usf_pkg::CTRLB_RST;
      ctrlc_reg <= usf_pkg::CTRLC_RST;
      baud_reg <= usf_pkg::BAUD_RST;
    end else if (wr_acc) begin
      case (paddr)
        usf_pkg::ADDR_CTRLB: ctrlb_reg <= pwdata[1:0];
        usf_pkg::ADDR_CTRLC: ctrlc_reg <= pwdata[9:0];
        usf_pkg::ADDR_BAUD: baud_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bit clocks
  logic rxd_s1, rxd_s2, rxd_prev;
  logic sck_s1, sck_s2, sck_reg, sck_prev;
  logic sck_now, sck_rise, sck_fall, tick;
  logic [15:0] divisor;
  logic [3:0] tx_tcnt_reg;
  logic [3:0] spb_last, half_last;
  logic tx_bit_en;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      rxd_prev <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_prev <= 1'b0;
    end else begin
      rxd_s1 <= rxd_pin;
      rxd_s2 <= rxd_s1;
      rxd_prev <= rxd_s2;
      sck_s1 <= transfer_clock_pin_in;
      sck_s2 <= sck_s1;
      sck_prev <= sck_now;
    end
  end

  // sync mode divides by the integer part only
  assign divisor = sync_m ? {baud_reg[15:6], 6'h00} : baud_reg;
  assign spb_last = dbl ? usf_pkg::SPB8_LAST : usf_pkg::SPB16_LAST;
  assign half_last = dbl ? usf_pkg::HALF8_LAST : usf_pkg::HALF16_LAST;

  usf_baud_gen u_baud (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .enable(rxen || txen || txd_oe),
    .divisor(divisor),
    .tick(tick)
  );

  // host toggles the clock once per tick: two ticks per bit in sync
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !sync_m || !host) sck_reg <= 1'b0;
    else if (tick) sck_reg <= !sck_reg;
  end

  assign sck_now = host ? sck_reg : sck_s2;
  assign sck_rise = sync_m && sck_now && !sck_prev;
  assign sck_fall = sync_m && !sck_now && sck_prev;
  assign transfer_clock_pin_out = sck_reg;
  assign transfer_clock_pin_oe = sync_m && host;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) tx_tcnt_reg <= 4'h0;
    else if (tick) tx_tcnt_reg <= (tx_tcnt_reg >= spb_last) ? 4'h0
                                   : tx_tcnt_reg + 4'h1;
  end

  // rising transfer clock starts a bit; falling edge samples it
  assign tx_bit_en = sync_m ? sck_rise
                     : (tick && tx_tcnt_reg >= spb_last);

  ////////////////////////////////////////////////////////////////////////
  // transmit path: data registers, buffer, shifter
  usf_pkg::usf_tx_st_t tx_st;
  logic [7:0] txd_lo_reg;
  logic txd_hi_reg, txd_full_reg, txb_full_reg, tx_on_reg, txc_reg;
  logic tx_line_reg, tx_stop_n_reg;
  logic [8:0] txb_reg, tx_sh_reg;
  logic [3:0] tx_idx_reg;
  logic tx_trig, tx_fin, tx_last;

  assign tx_trig = wr_acc && !txd_full_reg &&
    (is9l ? paddr == usf_pkg::ADDR_TX_HI
          : paddr == usf_pkg::ADDR_TX_LO);
  assign tx_last = tx_idx_reg == nbits - 4'h1;
  assign tx_fin = tx_bit_en && tx_st == usf_pkg::TX_STOP &&
                  (!stop2 || tx_stop_n_reg);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_st <= usf_pkg::TX_IDLE;
      txd_lo_reg <= 8'h00;
      txd_hi_reg <= 1'b0;
      txd_full_reg <= 1'b0;
      txb_full_reg <= 1'b0;
      txb_reg <= 9'h000;
      tx_sh_reg <= 9'h000;
      tx_idx_reg <= 4'h0;
      tx_line_reg <= 1'b1;
      tx_stop_n_reg <= 1'b0;
    end else begin
      if (wr_acc && !txd_full_reg && paddr == usf_pkg::ADDR_TX_LO)
        txd_lo_reg <= pwdata[7:0];
      if (wr_acc && !txd_full_reg && paddr == usf_pkg::ADDR_TX_HI)
        txd_hi_reg <= pwdata[0];
      if (tx_trig) txd_full_reg <= 1'b1;
      else if (txd_full_reg && !txb_full_reg) begin
        txd_full_reg <= 1'b0;
        txb_full_reg <= 1'b1;
        txb_reg <= {txd_hi_reg, txd_lo_reg};
      end
      if (tx_bit_en) begin
        case (tx_st)
          usf_pkg::TX_IDLE, usf_pkg::TX_STOP: begin
            if (tx_st == usf_pkg::TX_STOP && stop2 && !tx_stop_n_reg) begin
              tx_stop_n_reg <= 1'b1;
            end else if (txb_full_reg && tx_on_reg) begin
              tx_sh_reg <= txb_reg;
              txb_full_reg <= 1'b0;
              tx_st <= usf_pkg::TX_START;
              tx_line_reg <= 1'b0;
            end else begin
              tx_st <= usf_pkg::TX_IDLE;
              tx_line_reg <= 1'b1;
            end
          end
          usf_pkg::TX_START: begin
            tx_st <= usf_pkg::TX_DATA;
            tx_idx_reg <= 4'h0;
            tx_line_reg <= tx_sh_reg[0];
          end
          usf_pkg::TX_DATA: begin
            tx_stop_n_reg <= 1'b0;
            if (tx_last && par_en) begin
              tx_st <= usf_pkg::TX_PAR;
              tx_line_reg <= usf_pkg::par_of(tx_sh_reg, nbits,
                par_mode == usf_pkg::PAR_ODD);
            end else if (tx_last) begin
              tx_st <= usf_pkg::TX_STOP;
              tx_line_reg <= 1'b1;
            end else begin
              // bits above the character size are never reached
              tx_idx_reg <= tx_idx_reg + 4'h1;
              tx_line_reg <= tx_sh_reg[tx_idx_reg + 4'h1];
            end
          end
          usf_pkg::TX_PAR: begin
            tx_st <= usf_pkg::TX_STOP;
            tx_line_reg <= 1'b1;
          end
          default: tx_st <= usf_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // disable holds off until shifter, buffer and data registers drain
  always_ff @(posedge clk_sys) begin
    if (!rst_n) tx_on_reg <= 1'b0;
    else if (txen) tx_on_reg <= 1'b1;
    else if (tx_st == usf_pkg::TX_IDLE && !txd_full_reg && !txb_full_reg)
      tx_on_reg <= 1'b0;
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) txc_reg <= 1'b0;
    else if (tx_fin && !txd_full_reg && !txb_full_reg) txc_reg <= 1'b1;
    else if (wr_acc && paddr == usf_pkg::ADDR_STATUS &&
             pwdata[usf_pkg::ST_TXC_BIT]) txc_reg <= 1'b0;
  end

  assign txd_out = tx_line_reg;
  assign txd_oe = tx_on_reg;

  ////////////////////////////////////////////////////////////////////////
  // receiver
  usf_pkg::usf_rx_st_t rx_st;
  logic [3:0] rx_tcnt_reg, rx_idx_reg;
  logic [8:0] rx_sh_reg;
  logic rx_par_reg, rx_smp, rx_push, rx_parity_error_flag;

  assign rx_smp = sync_m ? sck_fall
    : (tick && rx_tcnt_reg == (rx_st == usf_pkg::RX_START ? half_last
                                                          : spb_last));
  assign rx_push = rxen && rx_smp && rx_st == usf_pkg::RX_STOP;
  assign rx_parity_error_flag = par_en && (rx_par_reg != usf_pkg::par_of(rx_sh_reg,
                   nbits, par_mode == usf_pkg::PAR_ODD));

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !rxen) begin
      rx_st <= usf_pkg::RX_IDLE;
      rx_tcnt_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rx_par_reg <= 1'b0;
    end else begin
      if (tick) rx_tcnt_reg <= rx_smp ? 4'h0 : rx_tcnt_reg + 4'h1;
      case (rx_st)
        usf_pkg::RX_IDLE: begin
          rx_tcnt_reg <= 4'h0;
          rx_idx_reg <= 4'h0;
          rx_sh_reg <= 9'h000;
          if (sync_m && sck_fall && !rxd_s2) rx_st <= usf_pkg::RX_DATA;
          else if (!sync_m && !rxd_s2 && rxd_prev)
            rx_st <= usf_pkg::RX_START;
        end
        usf_pkg::RX_START: begin
          // a start bit gone high by mid-bit is a glitch, not a frame
          if (rx_smp) rx_st <= rxd_s2 ? usf_pkg::RX_IDLE
                                      : usf_pkg::RX_DATA;
        end
        usf_pkg::RX_DATA: begin
          if (rx_smp) begin
            rx_sh_reg[rx_idx_reg] <= rxd_s2;
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == nbits - 4'h1)
              rx_st <= par_en ? usf_pkg::RX_PAR : usf_pkg::RX_STOP;
          end
        end
        usf_pkg::RX_PAR: begin
          if (rx_smp) begin
            rx_par_reg <= rxd_s2;
            rx_st <= usf_pkg::RX_STOP;
          end
        end
        usf_pkg::RX_STOP: begin
          if (rx_smp) rx_st <= usf_pkg::RX_IDLE;
        end
        default: rx_st <= usf_pkg::RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive buffer: entry 0 is the oldest frame
  // entry layout: {ovf, frame_error_flag, parity_error_flag, data[8:0]}
  logic [11:0] rxb_mem [0:1];
  logic [1:0] rxb_cnt_reg;
  logic rd_ok_reg, rx_pop;
  logic [11:0] rx_new;

  assign rx_pop = rd_acc && rd_ok_reg &&
    paddr == (is9l ? usf_pkg::ADDR_RX_HI
                   : usf_pkg::ADDR_RX_LO);
  assign rx_new = {1'b0, !rxd_s2, rx_parity_error_flag, rx_sh_reg};

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !rxen) begin
      rxb_cnt_reg <= 2'h0;
      rxb_mem[0] <= 12'h000;
      rxb_mem[1] <= 12'h000;
    end else begin
      if (rx_pop) rxb_mem[0] <= rxb_mem[1];
      if (rx_push && rxb_cnt_reg == 2'h2 && !rx_pop)
        rxb_mem[1][11] <= 1'b1;
      else if (rx_push && (rxb_cnt_reg == 2'h0 ||
               (rxb_cnt_reg == 2'h1 && rx_pop)))
        rxb_mem[0] <= rx_new;
      else if (rx_push) rxb_mem[1] <= rx_new;
      if (rx_pop && !rx_push) rxb_cnt_reg <= rxb_cnt_reg - 2'h1;
      else if (rx_push && !rx_pop && rxb_cnt_reg != 2'h2)
        rxb_cnt_reg <= rxb_cnt_reg + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase
  logic rxc;
  assign rxc = rxb_cnt_reg != 2'h0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      rd_ok_reg <= 1'b0;
    end else if (rd_setup) begin
      rd_ok_reg <= rxc;
      prdata <= 32'h0000_0000;
      case (paddr)
        usf_pkg::ADDR_RX_LO: prdata[7:0] <= rxb_mem[0][7:0];
        usf_pkg::ADDR_RX_HI: begin
          prdata[usf_pkg::RXH_D8_BIT] <= rxb_mem[0][8];
          prdata[usf_pkg::RXH_PAR_ERR_BIT] <= rxb_mem[0][9];
          prdata[usf_pkg::RXH_FRM_ERR_BIT] <= rxb_mem[0][10];
          prdata[usf_pkg::RXH_OVF_BIT] <= rxb_mem[0][11];
          prdata[usf_pkg::RXH_RXC_BIT] <= rxc;
        end
        usf_pkg::ADDR_TX_LO: prdata[7:0] <= txd_lo_reg;
        usf_pkg::ADDR_TX_HI: prdata[0] <= txd_hi_reg;
        usf_pkg::ADDR_STATUS: begin
          prdata[usf_pkg::ST_RXC_BIT] <= rxc;
          prdata[usf_pkg::ST_TXC_BIT] <= txc_reg;
          prdata[usf_pkg::ST_DRE_BIT] <= !txd_full_reg;
        end
        usf_pkg::ADDR_CTRLB: prdata[1:0] <= ctrlb_reg;
        usf_pkg::ADDR_CTRLC: prdata[9:0] <= ctrlc_reg;
        usf_pkg::ADDR_BAUD: prdata[15:0] <= baud_reg;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_start_bit_low: assert property (
    $changed(tx_st) && tx_st == usf_pkg::TX_START |-> !txd_out)
    else $error("start bit not low");
  a_stop_idle_high: assert property (
    tx_st == usf_pkg::TX_STOP || (tx_st == usf_pkg::TX_IDLE &&
      $past(tx_st) == usf_pkg::TX_STOP) |-> txd_out)
    else $error("stop or idle level not high");
  a_parity_value: assert property (
    tx_st == usf_pkg::TX_PAR |-> $past(tx_st) == usf_pkg::TX_DATA ||
      txd_out == usf_pkg::par_of(tx_sh_reg, nbits,
                                 par_mode == usf_pkg::PAR_ODD))
    else $error("wrong transmitted parity");
  a_txc_nothing_new: assert property (
    $rose(txc_reg) |-> $past(!txd_full_reg && !txb_full_reg &&
      tx_st == usf_pkg::TX_STOP))
    else $error("tx complete set with data pending");
  a_tx_off_drained: assert property (
    $fell(tx_on_reg) |-> tx_st == usf_pkg::TX_IDLE && !txb_full_reg
      && !txd_oe)
    else $error("transmitter released with data pending");
  a_rx_depth_two: assert property (
    rxb_cnt_reg != 2'h3)
    else $error("receive buffer beyond two frames");
  a_rx_overflow_mark: assert property (
    rx_push && rxb_cnt_reg == 2'h2 && !rx_pop |=> rxb_mem[1][11]
      && rxb_cnt_reg == 2'h2)
    else $error("overflow not flagged");
  a_rx_push_count: assert property (
    rx_push && !rx_pop && rxb_cnt_reg == 2'h0 |=> rxc && rxb_mem[0][8:0]
      == $past(rx_sh_reg))
    else $error("frame not moved into buffer");
  a_rx_fail_start: assert property (
    rx_st == usf_pkg::RX_START && rx_smp && rxd_s2 |=>
      rx_st == usf_pkg::RX_IDLE)
    else $error("false start bit accepted");
  c_tx_frame: cover property (tx_fin && txc_reg == 1'b0);
  c_rx_parity_err: cover property (rx_push && rx_parity_error_flag);
  c_rx_overflow: cover property (rx_push && rxb_cnt_reg == 2'h2);
  c_tx_back_to_back: cover property (tx_fin && txb_full_reg);
endmodule : usf_core

//--- tb/usf_remote.sv
/* usf_remote: far-end serial transceiver for asynchronous frames.
   assumes the bench sets bit_clk to the bit time in clk_sys cycles */
`timescale 1ns/1ps
module usf_remote (
  input wire logic clk_sys,
  input wire logic txd,
  output logic rxd,
  output logic sck
);
  int bit_clk = 16;
  int ck_cnt = 0;
  initial rxd = 1'b1;
  initial sck = 1'b0;
  // free-running host clock for sync client: 8 clk_sys a period
  always @(posedge clk_sys) begin
    ck_cnt <= (ck_cnt + 1) % 4;
    if (ck_cnt == 3) sck <= !sck;
  end
  // frames come ready made: start, data, parity, stops, lsb first
  task automatic send(input logic [12:0] f, input int len);
    for (int i = 0; i < len; i++) begin
      rxd <= f[i];
      repeat (bit_clk) @(posedge clk_sys);
    end
    rxd <= 1'b1;
    @(posedge clk_sys);
  endtask : send
  // stops at the close of the last bit so a following frame is caught
  task automatic recv(input int len, output logic [12:0] f);
    f = 13'h1fff;
    while (txd !== 1'b0) @(posedge clk_sys);
    repeat (bit_clk / 2) @(posedge clk_sys);
    for (int i = 0; i < len; i++) begin
      f[i] = txd;
      repeat (i < len - 1 ? bit_clk : bit_clk / 2) @(posedge clk_sys);
    end
  endtask : recv
endmodule : usf_remote

//--- tb/tb_usart_frame_baud_txrx_core.sv
/* tb_usart_frame_baud_txrx_core: frame format table, then edge cases.
   assumes usf_core on APB and usf_remote on the serial line */
`timescale 1ns/1ps
module tb_usart_frame_baud_txrx_core;
  typedef struct {
    logic [9:0] cc;
    logic [15:0] bd;
    logic [8:0] d;
  } usf_row_t;
  // control word, baud setting, data
  usf_row_t rows[6] = '{'{10'h000, 16'h0040, 9'h1f5},
    '{10'h061, 16'h0040, 9'h0a5}, '{10'h032, 16'h0060, 9'h155},
    '{10'h123, 16'h0080, 9'h0c3}, '{10'h036, 16'h0040, 9'h1a5},
    '{10'h067, 16'h0040, 9'h13c}};
  // reset values seen as {data[30:0], slave error}
  logic [7:0] ra[4] = '{usf_pkg::ADDR_CTRLC, usf_pkg::ADDR_BAUD,
    usf_pkg::ADDR_STATUS, 8'h20};
  logic [31:0] rv[4] = '{32'h6, 32'h80, 32'h40, 32'h1};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, eh, el;
  logic pready, pslverr, rxd_pin, txd_out, txd_oe, err;
  logic [12:0] got, fa, fb;
  logic ck_rem, ck_out, ck_oe;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int len, n;

  usf_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_pin(rxd_pin), .txd_out(txd_out), .txd_oe(txd_oe),
    .transfer_clock_pin_in(ck_rem), .transfer_clock_pin_out(ck_out),
    .transfer_clock_pin_oe(ck_oe));
  // a released pin shows the inverse level so a leak is seen
  usf_remote rem (.clk_sys(clk_sys), .txd(txd_oe ? txd_out : !txd_out),
    .rxd(rxd_pin), .sck(ck_rem));

  initial forever #20 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic chkl(input logic [12:0] g, input logic [12:0] e);
    chk({19'h0, g}, {19'h0, e});
  endtask : chkl

  // setup after an edge, held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tx_word(input logic l9, input logic [8:0] d);
    if (l9) apb(usf_pkg::ADDR_TX_LO, 1'b1, {24'h0, d[7:0]});
    apb(usf_pkg::ADDR_TX_HI, 1'b1, {31'h0, d[8]});
    if (!l9) apb(usf_pkg::ADDR_TX_LO, 1'b1, {24'h0, d[7:0]});
  endtask : tx_word

  task automatic rx_pair(input logic l9, input logic [31:0] h, l);
    apb(l9 ? usf_pkg::ADDR_RX_LO : usf_pkg::ADDR_RX_HI, 1'b0, 32'h0);
    chk(q, l9 ? l : h);
    apb(l9 ? usf_pkg::ADDR_RX_HI : usf_pkg::ADDR_RX_LO, 1'b0, 32'h0);
    chk(q, l9 ? h : l);
  endtask : rx_pair

  // expected line bits, lsb first; stop bits stay at the ones filled in
  function automatic logic [12:0] frm(input logic [9:0] cc,
      input logic [8:0] d, output int ln, output int nb);
    logic p;
    nb = (cc[2:0] < 3'h4) ? 5 + int'(cc[2:0]) : (cc[2:1] == 2'h3) ? 9 : 8;
    frm = 13'h1fff;
    frm[0] = 1'b0;
    p = cc[4];
    for (int i = 0; i < nb; i++) begin
      frm[i + 1] = d[i];
      p = p ^ d[i];
    end
    if (cc[5]) frm[nb + 1] = p;
    ln = 2 + nb + int'(cc[5]) + int'(cc[6]);
  endfunction : frm
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      apb(ra[i], 1'b0, 32'h0);
      chk({q[30:0], err}, rv[i]);
    end
    apb(usf_pkg::ADDR_CTRLB, 1'b1, 32'h3);
    foreach (rows[i]) begin
      fa = frm(rows[i].cc, rows[i].d, len, n);
      rem.bit_clk = (rows[i].cc[8] ? 8 : 16) * int'(rows[i].bd) / 64;
      apb(usf_pkg::ADDR_BAUD, 1'b1, {16'h0, rows[i].bd});
      apb(usf_pkg::ADDR_CTRLC, 1'b1, {22'h0, rows[i].cc});
      apb(usf_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk(q & 32'h20, 32'h20);
      fork
        rem.recv(len, got);
        tx_word(rows[i].cc[2:0] == usf_pkg::CS_9L, rows[i].d);
      join
      chkl(got, fa);
      repeat (4) @(posedge clk_sys);
      apb(usf_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk(q & 32'h40, 32'h40);
      apb(usf_pkg::ADDR_STATUS, 1'b1, 32'h40);
      rem.send(fa, len);
      eh = 32'h80 | 32'(n == 9 && rows[i].d[8]);
      el = {24'h0, rows[i].d[7:0]} & ((32'h1 << n) - 32'h1);
      rx_pair(rows[i].cc[2:0] == usf_pkg::CS_9L, eh, el);
    end
    rem.bit_clk = 16;
    apb(usf_pkg::ADDR_BAUD, 1'b1, 32'h40);
    apb(usf_pkg::ADDR_CTRLC, 1'b1, 32'h23);
    fa = frm(10'h023, 9'h0c3, len, n);
    fa[9] = ~fa[9];
    rem.send(fa, len);
    rx_pair(1'b0, 32'h82, 32'hc3);
    fa[9] = ~fa[9];
    fa[10] = 1'b0;
    rem.send(fa, len);
    rx_pair(1'b0, 32'h84, 32'hc3);
    // sync host on its own clock, then client on the remote's clock
    rem.bit_clk = 8;
    apb(usf_pkg::ADDR_BAUD, 1'b1, 32'h100);
    fa = frm(10'h003, 9'h069, len, n);
    for (int k = 0; k < 2; k++) begin
      apb(usf_pkg::ADDR_CTRLC, 1'b1, k ? 32'h83 : 32'h283);
      @(negedge clk_sys);
      q[0] = ck_out;
      repeat (4) @(negedge clk_sys);
      chk({30'h0, ck_oe, ck_out ^ q[0]}, k ? 32'h0 : 32'h3);
      fork
        rem.recv(len, got);
        apb(usf_pkg::ADDR_TX_LO, 1'b1, 32'h69);
      join
      chkl(got, fa);
      rem.send(fa, len);
      repeat (8) @(posedge clk_sys);
      rx_pair(1'b0, 32'h80, 32'h69);
    end
    rem.bit_clk = 16;
    apb(usf_pkg::ADDR_BAUD, 1'b1, 32'h40);
    apb(usf_pkg::ADDR_CTRLC, 1'b1, 32'h3);
    // three frames unread: the third is lost, the newest kept one flagged
    for (int k = 1; k < 4; k++) begin
      fa = frm(10'h003, 9'(k * 17), len, n);
      rem.send(fa, len);
    end
    rx_pair(1'b0, 32'h80, 32'h11);
    rx_pair(1'b0, 32'hc0, 32'h22);
    apb(usf_pkg::ADDR_STATUS, 1'b0, 32'h0);
    chk(q & 32'h80, 32'h0);
    fa = frm(10'h003, 9'h05a, len, n);
    fb = frm(10'h003, 9'h0a5, len, n);
    fork
      begin
        rem.recv(len, got);
        chkl(got, fa);
        rem.recv(len, got);
        chkl(got, fb);
      end
      begin
        apb(usf_pkg::ADDR_TX_LO, 1'b1, 32'h5a);
        do apb(usf_pkg::ADDR_STATUS, 1'b0, 32'h0); while (q[5] !== 1'b1);
        apb(usf_pkg::ADDR_TX_LO, 1'b1, 32'ha5);
        apb(usf_pkg::ADDR_CTRLB, 1'b1, 32'h1);
        repeat (4) @(posedge clk_sys);
        chk({31'h0, txd_oe}, 32'h1);
      end
    join
    repeat (4) @(posedge clk_sys);
    chk({31'h0, txd_oe}, 32'h0);
    close_out();
  end
endmodule : tb_usart_frame_baud_txrx_core
